// ===== common/adcro_pkg.sv
// constants for the serial readout port of the two-channel converter
// assumes a single 250 MHz clock mclk; all counts are in mclk cycles
package adcro_pkg;

  // ==========================================================
  // clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int CLK_PERIOD_PS = 4_000;
  // crystal period, as printed 30.5176 us, held in ps
  localparam int XTAL_PERIOD_PS = 30_517_600;
  // conversion period, as printed 50.54 ms (19.79 Hz), held in ns
  localparam int CONV_PERIOD_NS = 50_540_000;

  // ==========================================================
  // derived cycle counts
  // one conversion period, longest time so rounded down
  localparam int CONV_CYC = CONV_PERIOD_NS / CLK_PERIOD_NS;
  // half a crystal period, generated clock high and low phases
  localparam int HALF_XTAL_CYC = XTAL_PERIOD_PS / (2 * CLK_PERIOD_PS);
  // data-low to first active edge, least t1/2 rounded up
  localparam int FIRST_EDGE_MIN_CYC = (XTAL_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // data-low to first active edge, most 3*t1/2 rounded down
  localparam int FIRST_EDGE_MAX_CYC = (3 * XTAL_PERIOD_PS / 2) / CLK_PERIOD_PS;
  // chosen delay: one crystal period, midway in the window
  localparam int FIRST_EDGE_CYC = XTAL_PERIOD_PS / CLK_PERIOD_PS;

  // ==========================================================
  // frame layout and reset values
  localparam int RESULT_BITS = 24;
  localparam int PIN_SYNC_W = 4;
  localparam int PIN_CS = 0;
  localparam int PIN_SCLK = 1;
  localparam int PIN_MODE = 2;
  localparam int PIN_CHAN = 3;
  localparam logic [3:0] PIN_RESET = 4'h000F;
  // strap read only once four filter stages hold the pin, not their reset level
  localparam logic [2:0] MODE_CAPTURE_AT = 3'h5;
  localparam logic [13:0] TMR_ZERO = 14'h0000;

endpackage : adcro_pkg

// ===== logic/adcro_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pin inputs; output moves when stages two and three agree
module adcro_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // pins and filtered levels
  input wire logic [W-1:0] pin_raw,
  output logic [W-1:0] pin_filt
);

  // ==========================================================
  // stages
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] filt_q;
  logic [W-1:0] filt_d;

  // stage one feeds stage two only; the filter looks at two and three
  assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q)) | (filt_q & s2_q & s3_q);

  // chain of flops, all reset to the idle pin level
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      filt_q <= INIT;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign pin_filt = filt_q;

endmodule : adcro_sync

// ===== logic/adcro_readout.sv
// serial readout port: conversion timer, result latch, 24-bit shifter,
// and the optional master clock generator
// assumes the analog front end presents a settled sample on mclk
// and that chip select, serial clock and strap pins are asynchronous
// Notes on behaviour
// - a new result is latched once per fixed conversion period
// - data pin is driven only while chip select is low
// - chip select high releases the data pin to high impedance
// - falling serial clock is active; data changes after each falling edge
// - after the last clock returns high, data goes high: nothing unread
// - strap low means external clock, strap high means device makes the clock
// - master: first falling edge between half and one and a half crystal periods
module adcro_readout
  import adcro_pkg::*;
#(
  parameter int DATA_W = adcro_pkg::RESULT_BITS,
  parameter int CONV_CYCLES = adcro_pkg::CONV_CYC,
  parameter int FIRST_EDGE_CYCLES = adcro_pkg::FIRST_EDGE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // front end side
  input wire logic [DATA_W-1:0] sample_data,
  output logic conv_done,
  output logic channel_sel,
  // strap and channel pins
  input wire logic mode_pin,
  input wire logic channel_select_pin,
  // serial port pins
  input wire logic cs_n,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  output logic dout,
  output logic dout_oe
);

  import adcro_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_WAIT, M_LOW, M_HIGH} adcro_mstate_t;

  localparam int CNT_W = $clog2(CONV_CYCLES);
  localparam int BIT_W = $clog2(DATA_W + 1);

  // ==========================================================
  // pin synchronisers
  logic [PIN_SYNC_W-1:0] pins_s;
  logic cs_n_s;
  logic sclk_s;

  adcro_sync #(
    .W(PIN_SYNC_W),
    .INIT(PIN_RESET)
  ) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin_raw({channel_select_pin, mode_pin, sclk_in, cs_n}),
    .pin_filt(pins_s)
  );

  assign cs_n_s = pins_s[PIN_CS];
  assign sclk_s = pins_s[PIN_SCLK];

  // ==========================================================
  // mode strap, taken once after reset release
  logic [2:0] cap_cnt_q;
  logic master_q;
  logic chan_q;

  // strap caught only after the synchroniser has filled
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cap_cnt_q <= 3'h0;
      master_q <= 1'b0;
    end else if (cap_cnt_q != MODE_CAPTURE_AT) begin
      cap_cnt_q <= cap_cnt_q + 3'h1;
      if (cap_cnt_q == MODE_CAPTURE_AT - 3'h1) begin
        master_q <= pins_s[PIN_MODE];
      end
    end
  end

  // channel choice passed to the front end, registered
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) chan_q <= 1'b0;
    else chan_q <= pins_s[PIN_CHAN];
  end

  // ==========================================================
  // conversion timer and result latch
  logic [CNT_W-1:0] conv_cnt_q;
  logic conv_tick;
  logic conv_done_q;
  logic [DATA_W-1:0] result_q;

  assign conv_tick = (conv_cnt_q == CNT_W'(CONV_CYCLES - 1));

  // free-running period, independent of reads
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      conv_cnt_q <= '0;
      conv_done_q <= 1'b0;
      result_q <= '0;
    end else begin
      conv_cnt_q <= conv_tick ? '0 : conv_cnt_q + CNT_W'(1);
      conv_done_q <= conv_tick;
      if (conv_tick) result_q <= sample_data;
    end
  end

  // ==========================================================
  // serial clock edges, from the pin or from the generator
  adcro_mstate_t fsm_q;
  adcro_mstate_t fsm_d;
  logic [13:0] tmr_q;
  logic tmr_done;
  logic sclk_q;
  logic sclk_prev_q;
  logic s_fall;
  logic s_rise;
  logic m_fall;
  logic m_rise;
  logic fall_ev;
  logic rise_ev;
  logic [BIT_W-1:0] bit_cnt_q;
  logic ready_q;
  logic dout_q;
  logic reading;
  logic done;

  assign reading = (bit_cnt_q != '0);
  assign s_fall = sclk_prev_q & ~sclk_s;
  assign s_rise = ~sclk_prev_q & sclk_s;
  assign tmr_done = (fsm_q == M_WAIT) ? (tmr_q == 14'(FIRST_EDGE_CYCLES - 1))
                                      : (tmr_q == 14'(HALF_XTAL_CYC - 1));
  assign m_fall = tmr_done && ((fsm_q == M_WAIT) || ((fsm_q == M_HIGH) && reading));
  assign m_rise = tmr_done && (fsm_q == M_LOW);
  // slave edges ignored in master mode and vice versa
  assign fall_ev = !cs_n_s && (master_q ? m_fall : s_fall);
  assign rise_ev = !cs_n_s && (master_q ? m_rise : s_rise);
  assign done = rise_ev && (bit_cnt_q == BIT_W'(DATA_W));

  // previous filtered pin level for edge detection
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) sclk_prev_q <= 1'b1;
    else sclk_prev_q <= sclk_s;
  end

  // generator: wait after data-low, then 24 full clock periods
  always_comb begin
    fsm_d = fsm_q;
    unique case (fsm_q)
      M_IDLE: if (master_q && !cs_n_s && ready_q && !reading && !dout_q) fsm_d = M_WAIT;
      M_WAIT: if (m_fall) fsm_d = M_LOW;
      M_LOW: if (m_rise) fsm_d = M_HIGH;
      M_HIGH: if (tmr_done) fsm_d = reading ? M_LOW : M_IDLE;
    endcase
    if (cs_n_s) fsm_d = M_IDLE;
  end

  // generator state, timer and clock level
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fsm_q <= M_IDLE;
      tmr_q <= TMR_ZERO;
      sclk_q <= 1'b1;
    end else begin
      fsm_q <= fsm_d;
      tmr_q <= (fsm_d != fsm_q || tmr_done) ? TMR_ZERO : tmr_q + 14'h0001;
      sclk_q <= (fsm_d != M_LOW);
    end
  end

  // ==========================================================
  // shifter and data pin
  logic [DATA_W-1:0] shift_q;
  logic send_bit;
  logic take_bit;
  logic ready_d;
  logic dout_d;
  logic dout_oe_q;

  // first active edge loads the latched result, msb goes out first
  assign take_bit = fall_ev && ready_q && (bit_cnt_q < BIT_W'(DATA_W));
  assign send_bit = reading ? shift_q[DATA_W-1] : result_q[DATA_W-1];
  // a new result arriving as the read ends keeps the flag set
  assign ready_d = conv_tick | (ready_q & ~done);

  // data pin level: low while a result waits, bits while reading
  assign dout_d = cs_n_s ? 1'b1 :
                  take_bit ? send_bit :
                  done ? 1'b1 :
                  reading ? dout_q : ~ready_q;

  // bit counter, shifter and ready flag
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q <= '0;
      shift_q <= '0;
      ready_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      if (cs_n_s || done) begin
        bit_cnt_q <= '0; // an aborted read leaves the result waiting
      end else if (take_bit) begin
        bit_cnt_q <= bit_cnt_q + BIT_W'(1);
        shift_q <= reading ? {shift_q[DATA_W-2:0], 1'b0} : {result_q[DATA_W-2:0], 1'b0};
      end
    end
  end

  // pin drivers registered
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dout_q <= 1'b1;
      dout_oe_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
      dout_oe_q <= !cs_n_s;
    end
  end

  assign dout = dout_q;
  assign dout_oe = dout_oe_q;
  assign sclk_out = sclk_q;
  assign sclk_oe = master_q;
  assign conv_done = conv_done_q;
  assign channel_sel = chan_q;

  // ==========================================================
  // checks
  logic [13:0] low_wait_q;

  // cycles since the data pin fell, before the first generated edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) low_wait_q <= TMR_ZERO;
    else if (dout_q || reading) low_wait_q <= TMR_ZERO;
    else if (low_wait_q != 14'h3FFF) low_wait_q <= low_wait_q + 14'h0001;
  end

  a_conv_latch: assert property (@(posedge mclk) disable iff (!nrst)
    conv_tick |=> ready_q && (result_q == $past(sample_data)) && conv_done)
    else $error("result not latched at end of conversion");

  a_drive_after_cs: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(dout_oe) |-> $past(!cs_n_s))
    else $error("data pin driven without chip select");

  a_release_on_cs: assert property (@(posedge mclk) disable iff (!nrst)
    cs_n_s |=> !dout_oe && !reading)
    else $error("data pin not released after chip select high");

  a_bit_on_fall: assert property (@(posedge mclk) disable iff (!nrst)
    take_bit |=> dout == $past(send_bit))
    else $error("data not updated after active edge");

  a_high_after_read: assert property (@(posedge mclk) disable iff (!nrst)
    (done && !cs_n_s) |=> dout && !reading ##1
      ($past(cs_n_s) || $past(take_bit) || (dout == !$past(ready_q))))
    else $error("data pin not high after last clock");

  a_mode_drive: assert property (@(posedge mclk) disable iff (!nrst)
    !master_q |-> !sclk_oe && (fsm_q == M_IDLE))
    else $error("clock driven in slave mode");

  a_first_edge: assert property (@(posedge mclk) disable iff (!nrst)
    (m_fall && fsm_q == M_WAIT && !cs_n_s) |->
      (low_wait_q >= 14'(FIRST_EDGE_MIN_CYC - 1)) && (low_wait_q <= 14'(FIRST_EDGE_MAX_CYC - 1)))
    else $error("first generated edge outside window");

  a_msb_first: assert property (@(posedge mclk) disable iff (!nrst)
    (take_bit && !reading) |=> (dout == $past(result_q[DATA_W-1])) && (bit_cnt_q == BIT_W'(1)))
    else $error("read did not start with msb");

  a_bit_bound: assert property (@(posedge mclk) disable iff (!nrst)
    bit_cnt_q <= BIT_W'(DATA_W))
    else $error("more than a full word shifted");

endmodule : adcro_readout

// ===== verif/adcro_host.sv
// ==========================================================
// host reader model for the serial readout port
// assumes tb_top calls its tasks; it drives pins on falling mclk
module adcro_host (
  // clock
  input wire logic mclk,
  // lines from the device
  input wire logic dout,
  input wire logic dout_oe,
  // lines to the device
  output logic cs_n,
  output logic sclk_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_q = 1'b1;

  // idle: deselected, external clock parked high
  initial begin
    cs_n = 1'b1;
    sclk_in = 1'b1;
  end

  // released line shows the inverse of its last level, never a stale copy
  task sel(input logic v);
    @(negedge mclk);
    cs_n = v;
  endtask : sel

  // one falling/rising pair; phases of 7 and 6 cycles clear the pin filter
  task clk_bit(output logic b);
    @(negedge mclk);
    sclk_in = 1'b0;
    repeat (7) @(negedge mclk);
    b = dout_oe ? dout : ~last_q;
    last_q = b;
    sclk_in = 1'b1;
    repeat (6) @(negedge mclk);
  endtask : clk_bit

  // shift in n bits, first bit lands at bit n-1, the top only when n is 24
  task read_word(output logic [23:0] w, input int n);
    logic b;
    w = 24'h00_0000;
    for (int i = 0; i < n; i++) begin
      clk_bit(b);
      w = {w[22:0], b};
    end
  endtask : read_word
endmodule : adcro_host

// ===== verif/tb_top.sv
// ==========================================================
// self-checking bench for adcro_readout, slave reads then master start
// assumes a shortened conversion period; master first-edge delay kept
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import adcro_pkg::*;
  localparam int CONV = 2000;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic mode_pin = 1'b0;
  logic chan_pin = 1'b0;
  logic [23:0] sample_data = 24'h00_0000;
  logic [23:0] model_q = 24'h00_0000;
  logic [23:0] word;
  logic b;
  bit rand_on = 1'b1;
  int fail_count = 0;
  int total_checks = 0;
  int seed = 32'hc7a4_87a9;
  int since = 0;
  int periods = 0;
  int k;
  wire cs_n, sclk_in, sclk_out, sclk_oe, dout, dout_oe, conv_done, channel_sel;

  // ==========================================================
  // design and reader
  adcro_readout #(.CONV_CYCLES(CONV)) DUT (
    .mclk(mclk), .nrst(nrst), .sample_data(sample_data), .conv_done(conv_done),
    .channel_sel(channel_sel), .mode_pin(mode_pin), .channel_select_pin(chan_pin),
    .cs_n(cs_n), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .dout(dout), .dout_oe(dout_oe));
  adcro_host host (.mclk(mclk), .dout(dout), .dout_oe(dout_oe), .cs_n(cs_n), .sclk_in(sclk_in));

  initial begin
    forever #2 mclk = ~mclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task end_of_test;
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // ==========================================================
  // model: sample moves mid-period only, so the tick edge never races it
  always @(negedge mclk) begin
    if (!nrst) begin
      since <= 0;
      periods <= 0;
    end else begin
      since <= since + 1;
      if (rand_on && since == CONV / 2) sample_data <= $random(seed);
      if (conv_done === 1'b1) begin
        if (periods > 0) check(since, CONV - 1);
        periods <= periods + 1;
        model_q <= sample_data;
        since <= 0;
      end
    end
  end

  // bounded wait for the next result, then let the model settle
  task wait_result;
    k = 0;
    while (conv_done !== 1'b1 && k < 3 * CONV) begin
      @(negedge mclk);
      k++;
    end
    check(k < 3 * CONV, 1'b1);
    repeat (2) @(negedge mclk);
  endtask : wait_result

  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    wait_result();
    check(sclk_oe, 1'b0);
    // clocks while deselected must not move anything
    host.clk_bit(b);
    host.clk_bit(b);
    for (int i = 0; i < 3; i++) begin
      wait_result();
      chan_pin = 1'($random(seed));
      check(dout_oe, 1'b0);
      host.sel(1'b0);
      repeat (8) @(negedge mclk);
      check(dout_oe, 1'b1);
      check(dout, 1'b0);
      check(channel_sel, chan_pin);
      // first pass aborts after five bits; the result must survive
      if (i == 0) begin
        host.read_word(word, 5);
        host.sel(1'b1);
        repeat (8) @(negedge mclk);
        check(dout_oe, 1'b0);
        host.sel(1'b0);
        repeat (8) @(negedge mclk);
        check(dout, 1'b0);
      end
      host.read_word(word, 24);
      check(word, model_q);
      repeat (8) @(negedge mclk);
      check(dout, 1'b1);
      host.sel(1'b1);
      repeat (8) @(negedge mclk);
      check(dout_oe, 1'b0);
    end
    // master: only the first bits, a whole frame is far too long
    rand_on = 1'b0;
    nrst = 1'b0;
    mode_pin = 1'b1;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    repeat (8) @(negedge mclk);
    check(sclk_oe, 1'b1);
    host.sel(1'b0);
    k = 0;
    while ((dout !== 1'b0 || dout_oe !== 1'b1) && k < 3 * CONV) begin
      @(negedge mclk);
      k++;
    end
    check(k < 3 * CONV, 1'b1);
    k = 1;
    while (sclk_out !== 1'b0 && k < 20000) begin
      @(negedge mclk);
      k++;
    end
    check(k >= FIRST_EDGE_MIN_CYC && k <= FIRST_EDGE_MAX_CYC, 1'b1);
    for (int i = 0; i < 3; i++) begin
      k = 0;
      while (sclk_out !== 1'b1 && k < 10000) begin
        @(negedge mclk);
        k++;
      end
      check(k < 10000, 1'b1);
      word = {word[22:0], dout};
      k = 0;
      while (sclk_out !== 1'b0 && k < 10000 && i < 2) begin
        @(negedge mclk);
        k++;
      end
      check(k < 10000, 1'b1);
    end
    check(word[2:0], model_q[23:21]);
    host.sel(1'b1);
    repeat (8) @(negedge mclk);
    check(dout_oe, 1'b0);
    end_of_test();
  end

  // hang guard, well past the roughly 37k cycles a clean run takes
  initial begin
    #(4 * 60_000);
    fail_count++;
    end_of_test();
  end
endmodule : tb_top
